// ==== core/can_ctl_pkg.sv ====
package can_ctl_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_MODE_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
	localparam logic [11:0] ADDR_MODE_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_TIMESTAMP = 12'h010;

	// ---------------------------------------------------------------
	// mode control field positions
	// ---------------------------------------------------------------
	localparam int BIT_VALID_FRAME = 7;
	localparam int BIT_RX_ACTIVE = 6;
	localparam int BIT_HALT_WAIT = 5;
	localparam int BIT_SYNCED = 4;
	localparam int BIT_TIMER_EN = 3;
	localparam int BIT_WAKE_EN = 2;
	localparam int BIT_SLEEP_RQ = 1;
	localparam int BIT_INIT_RQ = 0;

	// mode status field positions
	localparam int BIT_INIT_ACK = 0;
	localparam int BIT_SLEEP_ACK = 1;

	// interrupt status field positions
	localparam int IRQ_VALID_FRAME = 0;
	localparam int IRQ_WAKE = 1;
	localparam int IRQ_STAMP = 2;
	localparam int IRQ_W = 3;

	// ---------------------------------------------------------------
	// reset values and timestamp placement
	// ---------------------------------------------------------------
	localparam logic [7:0] MODE_CONTROL_RESET = 8'h01;
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [3:0] STAMP_OFS_HI = 4'hE;
	localparam logic [3:0] STAMP_OFS_LO = 4'hF;
	localparam int BIT_CLK_DIV = 50;

	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_INIT = 2'b01,
		MODE_SLEEP = 2'b10
	} mode_t;
endpackage

// ==== core/can_stamp_timer.sv ====
`timescale 1ns/1ns
module can_stamp_timer
	import can_ctl_pkg::*;
#(
	parameter int DIV = BIT_CLK_DIV
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	input wire logic enable, // timer runs while high
	output logic [15:0] count_q // free-running bit-rate count
);
	logic [15:0] div_q;
	logic tick;

	// -------------------------------------------------------------
	// bit-rate enable divider
	// -------------------------------------------------------------
	assign tick = (div_q == 16'(DIV - 1));

	// divider restarts with the timer so the first tick lands a full bit later
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_q <= 16'h0000;
		end else if (!enable || tick) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// counter clears whenever disabled
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_q <= TIMER_RESET;
		end else if (!enable) begin
			count_q <= TIMER_RESET;
		end else if (tick) begin
			count_q <= count_q + 16'h0001;
		end
	end
endmodule

// ==== core/can_mode_control_status.sv ====
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - valid frame sets sticky flag bit 7
// - flag clears on written one or in init
// - flags meaningless in loopback mode
// - bit 6 mirrors receiver activity
// - bit 5 halts clocks in wait
// - bit 4 shows bus synchronization
// - bit 3 starts 16-bit bit-rate timer
// - stamp goes to buffer bytes E,F
// - timer clears off; enable low in init
// - bit 2 wakes sleep on traffic
// - init holds register except wake,sleep,init
// - writable outside init; init bit always
// - reads are clock-aligned
// - init request aborts, then acknowledges
// - sleep only when bus idle
// - wake clears sleep request itself
// - transmit recessive in clock-halting wait or stop
module can_mode_control_status
	import can_ctl_pkg::*;
#(
	parameter int DIV = BIT_CLK_DIV
) (
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic rst, // async reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic rx_frame_ok, // pulse: valid frame received
	input wire logic rx_active, // receiver front end busy
	input wire logic bus_synced, // protocol engine synchronized
	input wire logic tx_pending, // any transmit buffer full
	input wire logic bus_traffic, // pulse: activity seen while asleep
	input wire logic msg_acked, // pulse: message acknowledged
	input wire logic cpu_wait, // cpu in wait mode
	input wire logic cpu_stop, // cpu in stop mode
	input wire logic core_tx, // protocol engine transmit level
	output logic bus_transmit_pin, // to transceiver, 1 recessive
	output logic abort_traffic, // engine abort and desync
	output logic iface_clk_en, // cpu interface clock enable
	output logic stamp_we, // pulse: write stamp to buffer
	output logic [3:0] stamp_ofs, // buffer byte offset, high byte
	output logic [15:0] stamp_data, // stamp, both bytes together
	output logic irq // level interrupt
);
	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic valid_frame_seen_q;
	logic receive_in_progress_q;
	logic halt_clocks_in_wait_q;
	logic bus_synchronized_q;
	logic timer_en_q;
	logic wake_on_traffic_enable_q;
	logic sleep_request_q;
	logic init_request_q;
	logic init_acknowledge_q;
	logic sleep_acknowledge_q;
	logic [IRQ_W-1:0] irq_status_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_event;
	logic [15:0] timer_count;
	logic in_init;
	logic wr;
	logic rd;
	logic hit;
	logic wr_ctl;
	logic [7:0] ctl_rd;
	logic bus_idle;
	logic wake_hit;
	mode_t mode_q;

	// -------------------------------------------------------------
	// apb decode
	// -------------------------------------------------------------
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign hit = (paddr == ADDR_MODE_CONTROL) || (paddr == ADDR_IRQ_STATUS) ||
		(paddr == ADDR_IRQ_MASK) || (paddr == ADDR_MODE_STATUS) || (paddr == ADDR_TIMESTAMP);
	assign wr_ctl = wr && (paddr == ADDR_MODE_CONTROL);
	assign in_init = init_request_q && init_acknowledge_q;
	assign bus_idle = !rx_active && !tx_pending;
	assign wake_hit = sleep_acknowledge_q && wake_on_traffic_enable_q && bus_traffic;

	assign ctl_rd = {valid_frame_seen_q, receive_in_progress_q, halt_clocks_in_wait_q,
		bus_synchronized_q, timer_en_q, wake_on_traffic_enable_q, sleep_request_q, init_request_q};

	// every access answers with no wait state: setup, then access with ready high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
		end
	end

	// read data captured from flopped state during setup, so it is clock aligned
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (rd) begin
			case (paddr)
				ADDR_MODE_CONTROL: prdata <= {24'h00_0000, ctl_rd};
				ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status_q};
				ADDR_IRQ_MASK: prdata <= {29'h0, irq_mask_q};
				ADDR_MODE_STATUS: prdata <= {30'h0, sleep_acknowledge_q, init_acknowledge_q};
				ADDR_TIMESTAMP: prdata <= {16'h0000, timer_count};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// -------------------------------------------------------------
	// mode control register
	// -------------------------------------------------------------
	// valid-frame flag: set beats a same-cycle write-one clear; filters ignored.
	// in loopback the engine's pulse is passed through but means nothing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			valid_frame_seen_q <= 1'b0;
		end else if (in_init) begin
			valid_frame_seen_q <= 1'b0;
		end else if (rx_frame_ok) begin
			valid_frame_seen_q <= 1'b1;
		end else if (wr_ctl && pwdata[BIT_VALID_FRAME]) begin
			valid_frame_seen_q <= 1'b0;
		end
	end

	// read-only live status, registered once from the engine
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			receive_in_progress_q <= 1'b0;
			bus_synchronized_q <= 1'b0;
		end else begin
			receive_in_progress_q <= rx_active && !in_init;
			bus_synchronized_q <= bus_synced && !init_request_q;
		end
	end

	// plain writable bits, locked and held at reset while initializing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			halt_clocks_in_wait_q <= MODE_CONTROL_RESET[BIT_HALT_WAIT];
			timer_en_q <= MODE_CONTROL_RESET[BIT_TIMER_EN];
		end else if (in_init) begin
			halt_clocks_in_wait_q <= MODE_CONTROL_RESET[BIT_HALT_WAIT];
			timer_en_q <= 1'b0;
		end else if (wr_ctl) begin
			halt_clocks_in_wait_q <= pwdata[BIT_HALT_WAIT];
			timer_en_q <= pwdata[BIT_TIMER_EN];
		end
	end

	// wake enable survives init; writable only outside it.
	// a change during sleep is still honoured here, software must not rely on it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wake_on_traffic_enable_q <= MODE_CONTROL_RESET[BIT_WAKE_EN];
		end else if (wr_ctl && !in_init) begin
			wake_on_traffic_enable_q <= pwdata[BIT_WAKE_EN];
		end
	end

	// sleep request: cpu may not clear it before sleep is acknowledged
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sleep_request_q <= MODE_CONTROL_RESET[BIT_SLEEP_RQ];
		end else if (wake_hit) begin
			sleep_request_q <= 1'b0;
		end else if (wr_ctl && !in_init) begin
			if (pwdata[BIT_SLEEP_RQ] || sleep_acknowledge_q || !sleep_request_q) begin
				sleep_request_q <= pwdata[BIT_SLEEP_RQ];
			end
		end
	end

	// init request: writable always, clear refused until acknowledged
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			init_request_q <= MODE_CONTROL_RESET[BIT_INIT_RQ];
		end else if (wr_ctl) begin
			if (pwdata[BIT_INIT_RQ] || init_acknowledge_q) begin
				init_request_q <= pwdata[BIT_INIT_RQ];
			end
		end
	end

	// -------------------------------------------------------------
	// mode sequencer
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_INIT;
		end else begin
			case (mode_q)
				MODE_RUN: begin
					if (init_request_q) begin
						mode_q <= MODE_INIT;
					end else if (sleep_request_q && bus_idle) begin
						mode_q <= MODE_SLEEP;
					end
				end
				MODE_INIT: begin
					if (!init_request_q) begin
						mode_q <= MODE_RUN;
					end
				end
				MODE_SLEEP: begin
					if (init_request_q) begin
						mode_q <= MODE_INIT;
					end else if (!sleep_request_q || wake_hit) begin
						mode_q <= MODE_RUN;
					end
				end
				default: mode_q <= MODE_INIT;
			endcase
		end
	end

	// acknowledges follow the sequencer one cycle later
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			init_acknowledge_q <= 1'b0;
			sleep_acknowledge_q <= 1'b0;
		end else begin
			init_acknowledge_q <= (mode_q == MODE_INIT) && init_request_q;
			sleep_acknowledge_q <= (mode_q == MODE_SLEEP) && sleep_request_q;
		end
	end

	// -------------------------------------------------------------
	// pins and engine controls
	// -------------------------------------------------------------
	// recessive at once on init request, clock-halting wait, or stop
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_transmit_pin <= 1'b1;
			abort_traffic <= 1'b1;
			iface_clk_en <= 1'b1;
		end else begin
			bus_transmit_pin <= core_tx || init_request_q || cpu_stop ||
				(cpu_wait && halt_clocks_in_wait_q);
			abort_traffic <= init_request_q;
			iface_clk_en <= !(cpu_wait && halt_clocks_in_wait_q);
		end
	end

	// -------------------------------------------------------------
	// timestamp
	// -------------------------------------------------------------
	can_stamp_timer #(
		.DIV(DIV)
	) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.enable(timer_en_q && !in_init),
		.count_q(timer_count)
	);

	// both bytes taken in one cycle at the acknowledge, never torn
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stamp_we <= 1'b0;
			stamp_ofs <= STAMP_OFS_HI;
			stamp_data <= TIMER_RESET;
		end else begin
			stamp_we <= msg_acked && timer_en_q;
			stamp_ofs <= STAMP_OFS_HI;
			if (msg_acked && timer_en_q) begin
				stamp_data <= timer_count;
			end
		end
	end

	// -------------------------------------------------------------
	// interrupts
	// -------------------------------------------------------------
	assign irq_event = {msg_acked && timer_en_q, wake_hit, rx_frame_ok};

	// sticky status: set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_status_q <= '0;
			irq_mask_q <= '0;
		end else begin
			for (int i = 0; i < IRQ_W; i++) begin
				if (irq_event[i]) begin
					irq_status_q[i] <= 1'b1;
				end else if (wr && paddr == ADDR_IRQ_STATUS && pwdata[i]) begin
					irq_status_q[i] <= 1'b0;
				end
			end
			if (wr && paddr == ADDR_IRQ_MASK) begin
				irq_mask_q <= pwdata[IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q);
		end
	end
endmodule

// ==== verif/can_ctl_asserts.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// port checks for the mode control block
// ---------------------------------------------------------------
module can_ctl_asserts (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic msg_acked, // ack pulse
	input wire logic cpu_wait, // cpu wait mode
	input wire logic cpu_stop, // cpu stop mode
	input wire logic bus_transmit_pin, // 1 recessive
	input wire logic iface_clk_en, // interface clock enable
	input wire logic stamp_we, // stamp write pulse
	input wire logic [3:0] stamp_ofs // stamp byte offset
);
	// one clock domain, so defaults keep each property short
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_stamp_cause: assert property (stamp_we |-> $past(msg_acked))
		else $error("stamp without ack");
	a_stamp_pulse: assert property (stamp_we |=> !stamp_we)
		else $error("stamp pulse too long");
	a_stamp_offset: assert property (stamp_we |-> stamp_ofs == 4'hE)
		else $error("stamp offset wrong");
	a_wait_gate: assert property (!iface_clk_en |-> $past(cpu_wait))
		else $error("clock gated outside wait");
	a_stop_recessive: assert property (cpu_stop |=> bus_transmit_pin)
		else $error("pin dominant in stop");
	c_stamp: cover property (stamp_we);
	c_err: cover property (pslverr);
	c_wait: cover property (!iface_clk_en);
endmodule

bind can_mode_control_status can_ctl_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .msg_acked(msg_acked), .cpu_wait(cpu_wait),
	.cpu_stop(cpu_stop), .bus_transmit_pin(bus_transmit_pin), .iface_clk_en(iface_clk_en),
	.stamp_we(stamp_we), .stamp_ofs(stamp_ofs));

// ==== verif/can_engine_model.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// protocol engine and transceiver stand-in
// ---------------------------------------------------------------
module can_engine_model (
	input wire logic clk_sys, // system clock
	output logic rx_frame_ok, // pulse: good frame
	output logic rx_active, // receiving
	output logic bus_synced, // synchronized
	output logic tx_pending, // transmit buffer full
	output logic bus_traffic, // pulse: bus activity
	output logic msg_acked, // pulse: ack seen
	output logic core_tx // engine transmit level
);
	initial begin
		{rx_frame_ok, rx_active, bus_synced, tx_pending, bus_traffic, msg_acked} = 6'h00;
		core_tx = 1'b1;
	end
	// engine toggles its level so a pin that is not forced shows it
	always @(posedge clk_sys) begin
		core_tx <= ~core_tx;
	end
	// one-cycle pulses: bit0 frame, bit1 ack, bit2 traffic
	task pulse(input logic [2:0] k);
		@(posedge clk_sys);
		{bus_traffic, msg_acked, rx_frame_ok} <= k;
		@(posedge clk_sys);
		{bus_traffic, msg_acked, rx_frame_ok} <= 3'h0;
	endtask
	// receiver, sync and transmit-buffer levels
	task level(input logic rx, sy, tp);
		@(posedge clk_sys);
		rx_active <= rx;
		bus_synced <= sy;
		tx_pending <= tp;
	endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// register and mode tests
// ---------------------------------------------------------------
module testbench;
	import can_ctl_pkg::*;
	logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cpu_wait = 0, cpu_stop = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rq;
	logic pready, pslverr, rx_frame_ok, rx_active, bus_synced, tx_pending, bus_traffic, msg_acked, core_tx;
	logic bus_transmit_pin, abort_traffic, iface_clk_en, stamp_we, irq, rerr, pin_s;
	logic [3:0] stamp_ofs;
	logic [15:0] stamp_data;
	int n_mismatch = 0, compares = 0;
	always #10 clk_sys = ~clk_sys;
	can_mode_control_status #(.DIV(2)) u_can_mode_control_status (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_frame_ok(rx_frame_ok), .rx_active(rx_active), .bus_synced(bus_synced),
		.tx_pending(tx_pending), .bus_traffic(bus_traffic), .msg_acked(msg_acked), .cpu_wait(cpu_wait),
		.cpu_stop(cpu_stop), .core_tx(core_tx), .bus_transmit_pin(bus_transmit_pin),
		.abort_traffic(abort_traffic), .iface_clk_en(iface_clk_en), .stamp_we(stamp_we),
		.stamp_ofs(stamp_ofs), .stamp_data(stamp_data), .irq(irq));
	can_engine_model u_can_engine_model (.clk_sys(clk_sys), .rx_frame_ok(rx_frame_ok), .rx_active(rx_active),
		.bus_synced(bus_synced), .tx_pending(tx_pending), .bus_traffic(bus_traffic), .msg_acked(msg_acked),
		.core_tx(core_tx));
	task chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// one transfer; holds the request until ready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		// answer taken at the same edge that sees ready high
		rq = prdata;
		rerr = pslverr;
		chk("ready", 1, n < 50);
		psel <= 0; penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(nm, e, rq);
	endtask
	// polls a bit with a bounded number of reads
	task poll(input string nm, input logic [11:0] a, input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(0, a, 32'h0);
			n++;
		end while (rq[b] !== v && n < 30);
		chk(nm, v, rq[b]);
	endtask
	task close_out;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		close_out;
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 0;
		rd("ctl_reset", ADDR_MODE_CONTROL, 32'h01);
		poll("init_ack", ADDR_MODE_STATUS, BIT_INIT_ACK, 1);
		// keeps the init request set so only the write lock is exercised
		wr(ADDR_MODE_CONTROL, 32'h0D);
		rd("ctl_locked", ADDR_MODE_CONTROL, 32'h01);
		wr(ADDR_MODE_CONTROL, 32'h00);
		poll("init_exit", ADDR_MODE_STATUS, BIT_INIT_ACK, 0);
		$display("test init done");
		u_can_engine_model.level(1, 1, 0);
		wr(ADDR_MODE_CONTROL, 32'h00);
		rd("ro_bits", ADDR_MODE_CONTROL, 32'h50);
		u_can_engine_model.level(0, 0, 0);
		$display("test status done");
		wr(ADDR_IRQ_MASK, 32'h1);
		u_can_engine_model.pulse(3'h1);
		repeat (2) @(posedge clk_sys);
		#1 chk("irq_on", 1, irq);
		rd("frame", ADDR_MODE_CONTROL, 32'h80);
		wr(ADDR_MODE_CONTROL, 32'h00);
		rd("frame_w0", ADDR_MODE_CONTROL, 32'h80);
		wr(ADDR_MODE_CONTROL, 32'h80);
		rd("frame_w1", ADDR_MODE_CONTROL, 32'h00);
		wr(ADDR_IRQ_STATUS, 32'h1);
		rd("irq_clr", ADDR_IRQ_STATUS, 32'h0);
		#1 chk("irq_off", 0, irq);
		apb(0, 12'h014, 32'h0);
		chk("unmapped", 1, rerr);
		chk("unmapped_rd", 0, rq);
		$display("test frame done");
		wr(ADDR_MODE_CONTROL, 32'h08);
		repeat (20) @(posedge clk_sys);
		u_can_engine_model.pulse(3'h2);
		#1 chk("stamp_we", 1, stamp_we);
		chk("stamp_ofs", 4'hE, stamp_ofs);
		// 22 clocks after enable at two clocks per bit tick
		chk("stamp_run", 32'd10, stamp_data);
		wr(ADDR_MODE_CONTROL, 32'h00);
		rd("timer_off", ADDR_TIMESTAMP, 32'h0);
		u_can_engine_model.pulse(3'h2);
		#1 chk("no_stamp", 0, stamp_we);
		$display("test timer done");
		wr(ADDR_MODE_CONTROL, 32'h20);
		cpu_wait <= 1;
		repeat (2) @(posedge clk_sys);
		#1 chk("clk_gate", 0, iface_clk_en);
		chk("pin_wait", 1, bus_transmit_pin);
		// the engine level toggles, so two forced samples in a row prove the force
		@(posedge clk_sys);
		#1 chk("pin_wait2", 1, bus_transmit_pin);
		@(posedge clk_sys);
		cpu_wait <= 0;
		wr(ADDR_MODE_CONTROL, 32'h00);
		cpu_wait <= 1;
		repeat (2) @(posedge clk_sys);
		#1 chk("clk_run", 1, iface_clk_en);
		pin_s = bus_transmit_pin;
		@(posedge clk_sys);
		#1 chk("pin_free", !pin_s, bus_transmit_pin);
		@(posedge clk_sys);
		cpu_wait <= 0;
		cpu_stop <= 1;
		repeat (2) @(posedge clk_sys);
		#1 chk("pin_stop", 1, bus_transmit_pin);
		@(posedge clk_sys);
		#1 chk("pin_stop2", 1, bus_transmit_pin);
		@(posedge clk_sys);
		cpu_stop <= 0;
		$display("test wait done");
		u_can_engine_model.level(0, 0, 1);
		wr(ADDR_MODE_CONTROL, 32'h04);
		wr(ADDR_MODE_CONTROL, 32'h06);
		repeat (10) @(posedge clk_sys);
		rd("no_sleep", ADDR_MODE_STATUS, 32'h0);
		u_can_engine_model.level(0, 0, 0);
		poll("sleep_ack", ADDR_MODE_STATUS, BIT_SLEEP_ACK, 1);
		u_can_engine_model.pulse(3'h4);
		poll("wake", ADDR_MODE_CONTROL, BIT_SLEEP_RQ, 0);
		// stamp bit is still set from the timer test
		rd("wake_irq", ADDR_IRQ_STATUS, 32'h6);
		$display("test sleep done");
		u_can_engine_model.level(0, 1, 0);
		wr(ADDR_MODE_CONTROL, 32'h0D);
		poll("reinit", ADDR_MODE_STATUS, BIT_INIT_ACK, 1);
		rd("init_hold", ADDR_MODE_CONTROL, 32'h05);
		rd("init_timer", ADDR_TIMESTAMP, 32'h0);
		chk("abort", 1, abort_traffic);
		$display("test reinit done");
		close_out;
	end
endmodule
